// File: verilog/src_top.v
`include "src_regs.vh"
module src_top #(
  parameter PUP_COUNT  = `SRC_PUP_COUNT,
  parameter WD_MAX_CYC = `SRC_WD_MAX_CYC
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        clk_en,
  input  wire        por_event,
  input  wire        bor_active,
  input  wire        xtal_ready,
  input  wire        rst_pin_i,
  output reg         rst_pin_o,
  output reg         rst_pin_oe,
  output reg         core_rst_r,
  output reg         pins_default_r,
  output reg  [15:0] fetch_addr_r,
  output reg         fetch_load_r,
  output reg         rc_osc_en_r,
  output reg         xtal_sel_r,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp
);
  // ******************************
  // States
  // ******************************
  localparam ST_RUN  = 5'b00001;
  localparam ST_HOLD = 5'b00010;
  localparam ST_PUP  = 5'b00100;
  localparam ST_WD   = 5'b01000;
  localparam ST_EXIT = 5'b10000;

  reg  [4:0]  state_r;
  reg  [4:0]  state_nxt;
  reg  [1:0]  pin_sync_r;
  reg  [2:0]  low_cnt_r;
  reg         ext_hold_r;
  reg  [2:0]  hold_cnt_r;
  reg         wd_rsten_r;
  reg         isp_en_r;
  reg         stop_r;
  reg         wdrf_r;
  reg         porf_r;
  reg         extrf_r;
  reg         borf_r;
  reg         swrf_r;
  reg         xt_r;
  reg         hfe_r;
  reg  [31:0] wd_cfg_r;
  reg  [31:0] wd_cnt_r;
  reg         wd_fire_r;
  reg         sw_req_r;
  reg         por_seen_r;
  reg         int_hold_r;
  reg         wr_pend_r;
  reg  [11:0] wr_addr_r;
  wire        pup_done;
  wire        pin_low;
  wire        int_src;
  wire        wr_now;
  wire [31:0] wd_limit;
  wire        kick;

  // ******************************
  // Pin synchroniser and qualifier
  // ******************************
  // Async entry in stop mode: pin low with stop set forces reset level
  wire stop_async = stop_r & ~rst_pin_i;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_sync_r <= 2'b11;
    end else if (clk_en) begin
      pin_sync_r <= {pin_sync_r[0], rst_pin_i};
    end
  end
  assign pin_low = ~pin_sync_r[1];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt_r  <= 3'h0;
      ext_hold_r <= 1'b0;
    end else if (clk_en) begin
      // Own drive restarts the count so our pulse tail is not taken
      if (!pin_low || rst_pin_oe) begin
        low_cnt_r  <= 3'h0;
        ext_hold_r <= ext_hold_r & pin_low;
      end else if (low_cnt_r < `SRC_EXT_QUAL - 1) begin
        low_cnt_r <= low_cnt_r + 3'h1;
      end else begin
        // Own drive is ignored so we never latch onto our own pulse
        ext_hold_r <= 1'b1;
      end
    end
  end

  // ******************************
  // Watchdog
  // ******************************
  assign kick     = wr_now && wr_addr_r == `SRC_OFF_CTRL &&
                    hwdata[`SRC_CTRL_WD_KICK];
  assign wd_limit = (wd_cfg_r == 32'h0 || wd_cfg_r > WD_MAX_CYC) ?
                    WD_MAX_CYC : wd_cfg_r;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_cnt_r  <= 32'h0;
      wd_fire_r <= 1'b0;
    end else if (clk_en) begin
      wd_fire_r <= 1'b0;
      if (core_rst_r || !wd_rsten_r || kick) begin
        wd_cnt_r <= 32'h0;
      end else if (wd_cnt_r >= wd_limit - 32'h1) begin
        wd_cnt_r  <= 32'h0;
        wd_fire_r <= 1'b1;
      end else begin
        wd_cnt_r <= wd_cnt_r + 32'h1;
      end
    end
  end

  // ******************************
  // Source merge and sequencer
  // ******************************
  assign int_src = bor_active | wd_fire_r | sw_req_r;

  src_cnt #(.W(24)) u_pup (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (clk_en),
    .clr     (state_r != ST_PUP),
    .run     (state_r == ST_PUP),
    .limit   (PUP_COUNT[23:0] - 24'h1),
    .done_r  (pup_done)
  );

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (por_event || bor_active || sw_req_r || ext_hold_r ||
            stop_async) begin
          state_nxt = ST_HOLD;
        end else if (wd_fire_r) begin
          state_nxt = ST_WD;
        end
      end
      ST_HOLD: begin
        if (por_event || por_seen_r && !pup_done) begin
          state_nxt = ST_PUP;
        end else if (!bor_active && !ext_hold_r &&
                     (!pin_low || rst_pin_oe) &&
                     !sw_req_r && !stop_async) begin
          state_nxt = ST_EXIT;
        end
      end
      ST_PUP: begin
        if (por_event) begin
          state_nxt = ST_PUP;
        end else if (pup_done) begin
          state_nxt = ST_HOLD;
        end
      end
      ST_WD: begin
        if (hold_cnt_r == `SRC_WD_HOLD - 1) begin
          if (int_src || ext_hold_r) begin
            state_nxt = ST_HOLD;
          end else begin
            state_nxt = ST_RUN;
          end
        end
      end
      ST_EXIT: begin
        if (int_src || ext_hold_r) begin
          state_nxt = ST_HOLD;
        end else begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_HOLD;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r    <= ST_PUP;
      hold_cnt_r <= 3'h0;
      por_seen_r <= 1'b1;
      int_hold_r <= 1'b0;
    end else if (clk_en) begin
      state_r    <= state_nxt;
      if (int_src) begin
        int_hold_r <= 1'b1;
      end else if (state_nxt == ST_RUN) begin
        int_hold_r <= 1'b0;
      end
      hold_cnt_r <= (state_r == ST_WD) ? hold_cnt_r + 3'h1 : 3'h0;
      if (por_event) begin
        por_seen_r <= 1'b1;
      end else if (state_r == ST_PUP && pup_done) begin
        por_seen_r <= 1'b0;
      end
    end
  end

  // ******************************
  // Core-facing outputs
  // ******************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_rst_r     <= 1'b1;
      pins_default_r <= 1'b1;
      fetch_addr_r   <= `SRC_RESET_VECTOR;
      fetch_load_r   <= 1'b0;
      rc_osc_en_r    <= 1'b1;
      xtal_sel_r     <= 1'b0;
      rst_pin_o      <= 1'b0;
      rst_pin_oe     <= 1'b1;
    end else if (clk_en) begin
      core_rst_r     <= (state_nxt != ST_RUN) | stop_async;
      pins_default_r <= (state_nxt != ST_RUN);
      fetch_addr_r   <= `SRC_RESET_VECTOR;
      fetch_load_r   <= (state_r != ST_RUN) && (state_nxt == ST_RUN);
      // RC always kept on in reset; crystal picked up once ready
      rc_osc_en_r    <= (state_nxt != ST_RUN) | ~xtal_sel_r | ~hfe_r;
      // First cycle after release always runs on RC
      xtal_sel_r     <= (state_r == ST_RUN) && (state_nxt == ST_RUN) &&
                        xt_r && hfe_r && xtal_ready;
      rst_pin_o      <= 1'b0;
      // Source drive is masked while ext_hold_r reports an external low on the pin; ST_WD and ST_PUP drive regardless
      rst_pin_oe     <= (state_nxt == ST_WD) || (state_nxt == ST_PUP) ||
                        ((state_nxt != ST_RUN) &&
                         (int_src || int_hold_r) &&
                         !ext_hold_r);
    end
  end

  // ******************************
  // AHB-Lite slave
  // ******************************
  assign wr_now = wr_pend_r;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h0;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (clk_en) begin
      wr_pend_r <= 1'b0;
      if (hsel && hready && htrans[1]) begin
        wr_pend_r <= hwrite;
        wr_addr_r <= haddr[11:0];
        if (!hwrite) begin
          case (haddr[11:0])
            `SRC_OFF_CTRL:
              hrdata <= {27'h0, stop_r, 1'b0, wd_rsten_r, isp_en_r, 1'b0};
            `SRC_OFF_STATUS:
              hrdata <= {25'h0, xtal_sel_r, core_rst_r, swrf_r, borf_r,
                         extrf_r, porf_r, wdrf_r};
            `SRC_OFF_WDOG_CFG: hrdata <= wd_cfg_r;
            `SRC_OFF_CLK_CTRL: hrdata <= {30'h0, hfe_r, xt_r};
            default:           hrdata <= 32'h0;
          endcase
        end
      end
    end
  end

  // ******************************
  // Control and flags
  // ******************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_rsten_r <= 1'b0;
      isp_en_r   <= 1'b0;
      stop_r     <= 1'b0;
      sw_req_r   <= 1'b0;
      wd_cfg_r   <= `SRC_WD_CFG_RST;
      wdrf_r     <= 1'b0;
      porf_r     <= 1'b1;
      extrf_r    <= 1'b0;
      borf_r     <= 1'b0;
      swrf_r     <= 1'b0;
      xt_r       <= 1'b0;
      hfe_r      <= 1'b0;
    end else if (clk_en) begin
      sw_req_r <= 1'b0;
      if (por_event) begin
        xt_r       <= 1'b0;
        hfe_r      <= 1'b0;
        wd_rsten_r <= 1'b0;
        wd_cfg_r   <= `SRC_WD_CFG_RST;
      end else if (core_rst_r) begin
        // Brownout and others keep clock bits and watchdog config
        wd_rsten_r <= 1'b0;
        isp_en_r   <= 1'b0;
        stop_r     <= 1'b0;
      end else if (wr_now) begin
        case (wr_addr_r)
          `SRC_OFF_CTRL: begin
            isp_en_r   <= hwdata[`SRC_CTRL_ISP_EN];
            wd_rsten_r <= hwdata[`SRC_CTRL_WD_RSTEN];
            stop_r     <= hwdata[`SRC_CTRL_STOP];
            sw_req_r   <= hwdata[`SRC_CTRL_RST_REQ] &&
                          (isp_en_r || hwdata[`SRC_CTRL_ISP_EN]);
          end
          `SRC_OFF_WDOG_CFG: wd_cfg_r <= hwdata;
          `SRC_OFF_CLK_CTRL: begin
            xt_r  <= hwdata[`SRC_CK_XT];
            hfe_r <= hwdata[`SRC_CK_HFE];
          end
          default: ;
        endcase
      end
      if (stop_async) begin
        stop_r <= 1'b0;
      end
      // Status: write one to clear, hardware set wins
      if (wr_now && wr_addr_r == `SRC_OFF_STATUS) begin
        wdrf_r  <= wdrf_r & ~hwdata[`SRC_ST_WDRF];
        porf_r  <= porf_r & ~hwdata[`SRC_ST_PORF];
        extrf_r <= extrf_r & ~hwdata[`SRC_ST_EXTRF];
        borf_r  <= borf_r & ~hwdata[`SRC_ST_BORF];
        swrf_r  <= swrf_r & ~hwdata[`SRC_ST_SWRF];
      end
      if (wd_fire_r) begin
        wdrf_r <= 1'b1;
      end
      if (por_event) begin
        porf_r <= 1'b1;
      end
      if (ext_hold_r || stop_async) begin
        extrf_r <= 1'b1;
      end
      if (bor_active) begin
        borf_r <= 1'b1;
      end
      if (sw_req_r) begin
        swrf_r <= 1'b1;
      end
    end
  end
endmodule

// File: verilog/src_regs.vh
`ifndef SRC_REGS_VH
`define SRC_REGS_VH
// ******************************
// Register offsets
// ******************************
`define SRC_OFF_CTRL      12'h000
`define SRC_OFF_STATUS    12'h004
`define SRC_OFF_WDOG_CFG  12'h008
`define SRC_OFF_CLK_CTRL  12'h00c
// ******************************
// Field positions
// ******************************
`define SRC_CTRL_RST_REQ  0
`define SRC_CTRL_ISP_EN   1
`define SRC_CTRL_WD_RSTEN 2
`define SRC_CTRL_WD_KICK  3
`define SRC_CTRL_STOP     4
`define SRC_ST_WDRF       0
`define SRC_ST_PORF       1
`define SRC_ST_EXTRF      2
`define SRC_ST_BORF       3
`define SRC_ST_SWRF       4
`define SRC_ST_INRST      5
`define SRC_ST_ONXTAL     6
`define SRC_CK_XT         0
`define SRC_CK_HFE        1
// ******************************
// Reset values and timing
// ******************************
`define SRC_RESET_VECTOR  16'h8000
`define SRC_WD_CFG_RST    32'h0000_0000
`define SRC_PUP_COUNT     65536
`define SRC_WD_HOLD       4
`define SRC_EXT_QUAL      4
`define SRC_EXT_EXIT      4
`define SRC_WD_MAX_NS     276000000
`define SRC_CLK_NS        8
`define SRC_WD_MAX_CYC    (`SRC_WD_MAX_NS / `SRC_CLK_NS)
`endif

// File: verilog/src_cnt.v
`include "src_regs.vh"
module src_cnt #(
  parameter W = 24
) (
  input  wire         hclk,
  input  wire         hresetn,
  input  wire         ce,
  input  wire         clr,
  input  wire         run,
  input  wire [W-1:0] limit,
  output reg          done_r
);
  reg  [W-1:0] cnt_r;
  wire [W-1:0] cnt_nxt;

  assign cnt_nxt = cnt_r + {{(W-1){1'b0}}, 1'b1};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r  <= {W{1'b0}};
      done_r <= 1'b0;
    end else if (ce) begin
      if (clr) begin
        cnt_r  <= {W{1'b0}};
        done_r <= 1'b0;
      end else if (run && !done_r) begin
        cnt_r  <= cnt_nxt;
        done_r <= (cnt_nxt >= limit);
      end
    end
  end
endmodule

// File: sim/src_checker.sv
// ****
// Port checks
// ****
module src_checker (
  input wire        hclk,
  input wire        hresetn,
  input wire        clk_en,
  input wire        bor_active,
  input wire        rst_pin_i,
  input wire        rst_pin_o,
  input wire        rst_pin_oe,
  input wire        core_rst_r,
  input wire        pins_default_r,
  input wire [15:0] fetch_addr_r,
  input wire        fetch_load_r,
  input wire        rc_osc_en_r,
  input wire        xtal_sel_r
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_vector_fixed: assert property (
    fetch_load_r |-> fetch_addr_r == 16'h8000) else $error("bad vector");
  chk_load_on_exit: assert property (
    $fell(core_rst_r) |-> fetch_load_r) else $error("no load pulse");
  chk_pins_default: assert property (
    core_rst_r |-> pins_default_r) else $error("pins not default");
  chk_rc_restart: assert property (
    $fell(core_rst_r) |-> rc_osc_en_r && !xtal_sel_r)
    else $error("not on rc at exit");
  chk_ext_enter: assert property (
    (clk_en && !rst_pin_i && !rst_pin_oe) [*8] |-> core_rst_r)
    else $error("pin low ignored");
  chk_ext_hold: assert property (
    (!rst_pin_i && !rst_pin_oe) [*3] ##0 core_rst_r |=> core_rst_r)
    else $error("left reset with pin low");
  chk_ext_exit: assert property (
    core_rst_r && !rst_pin_oe && $rose(rst_pin_i) |-> ##[1:7] !core_rst_r)
    else $error("slow exit");
  chk_pin_driven: assert property (
    rst_pin_oe |-> core_rst_r && !rst_pin_o) else $error("pin drive bad");
  chk_bor_hold: assert property (
    bor_active [*3] |-> core_rst_r && rst_pin_oe) else $error("bor not held");
endmodule
bind src_top src_checker src_checker_inst (.hclk, .hresetn, .clk_en,
  .bor_active, .rst_pin_i, .rst_pin_o, .rst_pin_oe, .core_rst_r,
  .pins_default_r, .fetch_addr_r, .fetch_load_r, .rc_osc_en_r,
  .xtal_sel_r);

// File: sim/src_pin_model.sv
// ****
// External supervisor on the reset pin
// ****
module src_pin_model (
  input  wire  hold_low,
  input  wire  force_high,
  input  wire  dut_oe,
  input  wire  dut_o,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-up idles high; a stiff driver can overpower the device
  assign pin = force_high ? 1'b1 :
               (hold_low | (dut_oe & !dut_o)) ? 1'b0 : 1'b1;
endmodule

// File: sim/tb_system_reset_controller.sv
`include "src_regs.vh"
module tb_system_reset_controller;
  timeunit 1ns;
  timeprecision 1ps;
  localparam PUP = 16;
  logic        hclk, hresetn, por_event, bor_active, xtal_ready;
  logic        hold_low, force_high, hsel, hwrite;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0]  htrans;
  logic        rst_pin_i, rst_pin_o, rst_pin_oe, core_rst_r;
  logic        pins_default_r, fetch_load_r, rc_osc_en_r, xtal_sel_r;
  logic        hreadyout, hresp;
  logic [15:0] fetch_addr_r;
  logic [31:0] hrdata;
  int          mismatches, check_count, n, c;
  src_top #(.PUP_COUNT(PUP), .WD_MAX_CYC(64)) src_top_inst (.hclk,
    .hresetn, .clk_en(1'b1), .por_event, .bor_active, .xtal_ready,
    .rst_pin_i, .rst_pin_o, .rst_pin_oe, .core_rst_r, .pins_default_r,
    .fetch_addr_r, .fetch_load_r, .rc_osc_en_r, .xtal_sel_r, .hsel,
    .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp);
  src_pin_model src_pin_model_inst (.hold_low, .force_high,
    .dut_oe(rst_pin_oe), .dut_o(rst_pin_o), .pin(rst_pin_i));
  // ****
  // Tasks
  // ****
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task rdy;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      print_verdict;
    end
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    rd = hrdata;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  // Bounded wait; k returns the edges spent
  task automatic wt(ref logic s, input logic v, output int k);
    k = 0;
    while (s !== v) begin
      @(posedge hclk);
      k++;
      if (k > 400) begin
        mismatches++;
        print_verdict;
      end
    end
  endtask
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // ****
  // Scenarios
  // ****
  initial begin
    {hresetn, por_event, bor_active, xtal_ready, hold_low} = 5'h0;
    {force_high, hsel, hwrite, htrans, haddr, hwdata} = '0;
    mismatches = 0;
    check_count = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    wt(core_rst_r, 1'b0, c);
    chk(c >= PUP, 1);
    wr(`SRC_OFF_STATUS, 32'h7f);
    rdc(12'h040, 32'hffffffff, 32'h0);
    wr(`SRC_OFF_CLK_CTRL, 32'h3);
    wr(`SRC_OFF_CTRL, 32'h1);
    repeat (10) @(posedge hclk);
    chk(core_rst_r, 0);
    force_high <= 1'b1;
    wr(`SRC_OFF_CTRL, 32'h3);
    wt(rst_pin_oe, 1'b1, c);
    chk({core_rst_r, rst_pin_i}, 2'h3);
    wt(core_rst_r, 1'b0, c);
    force_high <= 1'b0;
    rdc(`SRC_OFF_CLK_CTRL, 32'hffffffff, 32'h3);
    rdc(`SRC_OFF_STATUS, 32'h10, 32'h10);
    xtal_ready <= 1'b1;
    repeat (10) @(posedge hclk);
    chk(xtal_sel_r, 1);
    // Zero limit selects the longest interval
    wr(`SRC_OFF_WDOG_CFG, 32'h0);
    wr(`SRC_OFF_CTRL, 32'h4);
    repeat (3) begin
      repeat (40) @(posedge hclk);
      wr(`SRC_OFF_CTRL, 32'hc);
    end
    chk(core_rst_r, 0);
    wt(rst_pin_oe, 1'b1, c);
    chk(c >= 60 && c <= 72, 1);
    wt(rst_pin_oe, 1'b0, c);
    chk(c, 4);
    wt(core_rst_r, 1'b0, c);
    rdc(`SRC_OFF_STATUS, 32'h1, 32'h1);
    wr(`SRC_OFF_STATUS, 32'h1);
    rdc(`SRC_OFF_STATUS, 32'h1, 32'h0);
    hold_low <= 1'b1;
    repeat (2) @(posedge hclk);
    hold_low <= 1'b0;
    repeat (8) @(posedge hclk);
    chk(core_rst_r, 0);
    hold_low <= 1'b1;
    wt(core_rst_r, 1'b1, c);
    chk(c <= 8, 1);
    repeat (20) @(posedge hclk);
    chk({core_rst_r, rst_pin_oe}, 2'h2);
    hold_low <= 1'b0;
    wt(core_rst_r, 1'b0, c);
    chk(c <= 7, 1);
    rdc(`SRC_OFF_STATUS, 32'h4, 32'h4);
    wr(`SRC_OFF_CTRL, 32'h10);
    hold_low <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(core_rst_r, 1);
    hold_low <= 1'b0;
    wt(core_rst_r, 1'b0, c);
    wr(`SRC_OFF_STATUS, 32'h7f);
    bor_active <= 1'b1;
    repeat (10) @(posedge hclk);
    chk(core_rst_r, 1);
    bor_active <= 1'b0;
    wt(core_rst_r, 1'b0, c);
    chk(c < PUP, 1);
    rdc(`SRC_OFF_STATUS, 32'ha, 32'h8);
    por_event <= 1'b1;
    repeat (3) @(posedge hclk);
    por_event <= 1'b0;
    wt(core_rst_r, 1'b0, c);
    chk(c >= PUP, 1);
    rdc(`SRC_OFF_CLK_CTRL, 32'hffffffff, 32'h0);
    rdc(`SRC_OFF_STATUS, 32'h2, 32'h2);
    print_verdict;
  end
endmodule
